/* File: logic/event_flag_pkg.sv */
// Function
// - bit7 flags1 sets when requested mode is ready; clears on mode change
// - bit6 flags1 sets in receive after strength, gain, frequency correction; clears leaving receive
// - bit5 flags1 sets in transmit after amplifier ramp; clears leaving transmit
// - bit4 flags1 follows synth lock live in synth mode, receive, transmit
// - bit3 flags1 sets when strength exceeds limit in receive; clears leaving or write 1
// - bit2 flags1 sets on timeout; clears leaving receive or fifo empty
// - bit1 flags1 sets on preamble found; clears on write 1
// - bit0 flags1 sets on sync/address hit; clears leaving receive, fifo empty, w1c continuous
// - bit7 flags2 high exactly while fifo holds 66 bytes
// - bit6 flags2 high while fifo holds no bytes
// - bit5 flags2 high while fifo count strictly exceeds fill limit
// - bit4 flags2 sets on overrun except sleep; write 1 clears flags and flushes fifo
// - bit3 flags2 sets when packet sent in transmit; clears leaving transmit
// - bit2 flags2 sets in receive on last payload byte, crc gated unless disabled or keep set; clears fifo empty
// - bit1 flags2 sets in receive on crc pass; clears when fifo empty
// - bit0 flags2 sets on low battery; only software write 1 clears it
package event_flag_pkg;
  // ----------------------------------------
  // register map
  // ----------------------------------------
  localparam logic [7:0] IDX_FLAGS_PRIMARY = 8'h3e;
  localparam logic [7:0] IDX_FLAGS_QUEUE = 8'h3f;
  localparam logic [7:0] IDX_CONTROL = 8'h80;
  localparam logic [7:0] IDX_COUNT = 8'h81;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  // ----------------------------------------
  // field positions
  // ----------------------------------------
  localparam int B_MODE = 7;
  localparam int B_RXRDY = 6;
  localparam int B_TXRDY = 5;
  localparam int B_LOCK = 4;
  localparam int B_STRENGTH = 3;
  localparam int B_TIMEOUT = 2;
  localparam int B_PREAMBLE = 1;
  localparam int B_SYNC = 0;
  localparam int B_FULL = 7;
  localparam int B_EMPTY = 6;
  localparam int B_LEVEL = 5;
  localparam int B_OVERRUN = 4;
  localparam int B_SENT = 3;
  localparam int B_BODY = 2;
  localparam int B_CRC = 1;
  localparam int B_BATT = 0;
  localparam int C_CONT = 0;
  localparam int C_CRCON = 1;
  localparam int C_KEEP = 2;
  localparam logic [6:0] QUEUE_DEPTH = 7'h42;
  localparam logic [7:0] FLAGS_PRIMARY_RESET = 8'h00;
  localparam logic [7:0] FLAGS_QUEUE_RESET = 8'h40;
  // ----------------------------------------
  // modes and event inputs
  // ----------------------------------------
  typedef enum logic [2:0] {
    MODE_SLEEP, MODE_STANDBY, MODE_SYNTH, MODE_TX, MODE_RX
  } radio_mode_t;
  typedef struct packed {
    logic mode_settled_flag;
    logic rxSettled;
    logic txRampDone;
    logic synthLocked;
    logic timeout;
    logic preamble;
    logic syncHit;
    logic overrun;
    logic frameSent;
    logic lastByte;
    logic crcPass;
    logic batteryLow;
  } radio_events_t;
endpackage

/* File: logic/avalon_reg_port.sv */
`timescale 1ns/1ps
module avalon_reg_port (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic read,
  input wire logic write,
  input wire logic [7:0] address,
  input wire logic [31:0] writedata,
  input wire logic [31:0] rdValue,
  output logic waitrequest,
  output logic [31:0] readdata,
  output logic wrPulse,
  output logic [7:0] wrData
);
  // ----------------------------------------
  // one wait cycle, then accept
  // ----------------------------------------
  logic ack;
  logic next_ack;
  logic [31:0] next_readdata;
  always_comb
  begin
    next_ack = (read | write) & ~ack;
    next_readdata = next_ack ? rdValue : 32'h00000000;
  end
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ack <= 1'b0;
      waitrequest <= 1'b1;
      readdata <= 32'h00000000;
    end
    else
    begin
      ack <= next_ack;
      waitrequest <= ~next_ack;
      readdata <= next_readdata;
    end
  end
  assign wrPulse = ack & write;
  assign wrData = writedata[7:0];
endmodule // avalon_reg_port

/* File: logic/radio_event_flag_registers.sv */
// The implementer's own choice: the Avalon-MM register port.
`timescale 1ns/1ps
module radio_event_flag_registers (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic read,
  input wire logic write,
  input wire logic [7:0] address,
  input wire logic [31:0] writedata,
  output logic waitrequest,
  output logic [31:0] readdata,
  input wire event_flag_pkg::radio_mode_t radioMode,
  input wire event_flag_pkg::radio_events_t events,
  input wire logic [7:0] signal_strength_value,
  input wire logic [7:0] signal_strength_limit,
  input wire logic [5:0] queue_fill_limit,
  input wire logic queuePush,
  input wire logic queuePop,
  output logic queueFlush
);
  logic [7:0] flagsA;
  logic [7:0] flagsB;
  logic [7:0] control;
  logic [6:0] count;
  logic [7:0] next_flagsA;
  logic [7:0] next_flagsB;
  logic [7:0] next_control;
  logic [6:0] next_count;
  logic next_flush;
  event_flag_pkg::radio_mode_t prevMode;
  logic [31:0] rdValue;
  logic wrPulse;
  logic [7:0] wrData;
  logic wrA;
  logic wrB;
  logic modeChg;
  logic leaveRx;
  logic leaveTx;
  logic inRx;
  logic inTx;
  logic emptyNow;
  logic emptied;
  // ----------------------------------------
  // bus port
  // ----------------------------------------
  avalon_reg_port port (
    .clk(clk),
    .rst_n(rst_n),
    .read(read),
    .write(write),
    .address(address),
    .writedata(writedata),
    .rdValue(rdValue),
    .waitrequest(waitrequest),
    .readdata(readdata),
    .wrPulse(wrPulse),
    .wrData(wrData)
  );
  // read mux, no side effects
  always_comb
  begin
    case (address)
      event_flag_pkg::IDX_FLAGS_PRIMARY: rdValue = {24'h000000, flagsA};
      event_flag_pkg::IDX_FLAGS_QUEUE: rdValue = {24'h000000, flagsB};
      event_flag_pkg::IDX_CONTROL: rdValue = {24'h000000, control};
      event_flag_pkg::IDX_COUNT: rdValue = {25'h0000000, count};
      default: rdValue = 32'h00000000;
    endcase
  end
  // ----------------------------------------
  // flag logic
  // ----------------------------------------
  assign wrA = wrPulse && (address == event_flag_pkg::IDX_FLAGS_PRIMARY);
  assign wrB = wrPulse && (address == event_flag_pkg::IDX_FLAGS_QUEUE);
  assign modeChg = radioMode != prevMode;
  assign inRx = radioMode == event_flag_pkg::MODE_RX;
  assign inTx = radioMode == event_flag_pkg::MODE_TX;
  assign leaveRx = prevMode == event_flag_pkg::MODE_RX && !inRx;
  assign leaveTx = prevMode == event_flag_pkg::MODE_TX && !inTx;
  assign emptyNow = next_count == 7'h00;
  assign emptied = emptyNow && count != 7'h00;
  always_comb
  begin
    next_flagsA = flagsA;
    next_flagsB = flagsB;
    next_control = control;
    next_count = count;
    next_flush = 1'b0;
    if (wrPulse && address == event_flag_pkg::IDX_CONTROL)
      next_control = wrData;
    // fifo occupancy and overrun flush
    if (wrB && wrData[event_flag_pkg::B_OVERRUN] && flagsB[event_flag_pkg::B_OVERRUN])
    begin
      next_count = 7'h00;
      next_flush = 1'b1;
    end
    else if (queuePush && !queuePop && count != event_flag_pkg::QUEUE_DEPTH)
      next_count = count + 7'h01;
    else if (queuePop && !queuePush && count != 7'h00)
      next_count = count - 7'h01;
    // ----------------------------------------
    // primary flag next values
    // ----------------------------------------
    // mode ready
    if (modeChg)
      next_flagsA[event_flag_pkg::B_MODE] = 1'b0;
    else if (events.mode_settled_flag)
      next_flagsA[event_flag_pkg::B_MODE] = 1'b1;
    next_flagsA[event_flag_pkg::B_RXRDY] = inRx && !modeChg &&
      (flagsA[event_flag_pkg::B_RXRDY] || events.rxSettled);
    next_flagsA[event_flag_pkg::B_TXRDY] = inTx && !modeChg &&
      (flagsA[event_flag_pkg::B_TXRDY] || events.txRampDone);
    next_flagsA[event_flag_pkg::B_LOCK] = events.synthLocked &&
      (inRx || inTx || radioMode == event_flag_pkg::MODE_SYNTH);
    // strength over limit, set beats clear
    if (wrA && wrData[event_flag_pkg::B_STRENGTH])
      next_flagsA[event_flag_pkg::B_STRENGTH] = 1'b0;
    if (leaveRx)
      next_flagsA[event_flag_pkg::B_STRENGTH] = 1'b0;
    if (inRx && signal_strength_value > signal_strength_limit)
      next_flagsA[event_flag_pkg::B_STRENGTH] = 1'b1;
    if (leaveRx || emptied)
      next_flagsA[event_flag_pkg::B_TIMEOUT] = 1'b0;
    if (events.timeout)
      next_flagsA[event_flag_pkg::B_TIMEOUT] = 1'b1;
    if (wrA && wrData[event_flag_pkg::B_PREAMBLE])
      next_flagsA[event_flag_pkg::B_PREAMBLE] = 1'b0;
    if (events.preamble)
      next_flagsA[event_flag_pkg::B_PREAMBLE] = 1'b1;
    if (leaveRx || emptied ||
        (wrA && wrData[event_flag_pkg::B_SYNC] && control[event_flag_pkg::C_CONT]))
      next_flagsA[event_flag_pkg::B_SYNC] = 1'b0;
    if (events.syncHit)
      next_flagsA[event_flag_pkg::B_SYNC] = 1'b1;
    // ----------------------------------------
    // queue flag next values
    // ----------------------------------------
    // queue levels follow the count
    next_flagsB[event_flag_pkg::B_FULL] = next_count == event_flag_pkg::QUEUE_DEPTH;
    next_flagsB[event_flag_pkg::B_EMPTY] = emptyNow;
    next_flagsB[event_flag_pkg::B_LEVEL] = next_count > {1'b0, queue_fill_limit};
    if (next_flush)
      next_flagsB[event_flag_pkg::B_OVERRUN] = 1'b0;
    if (events.overrun && radioMode != event_flag_pkg::MODE_SLEEP)
      next_flagsB[event_flag_pkg::B_OVERRUN] = 1'b1;
    if (leaveTx)
      next_flagsB[event_flag_pkg::B_SENT] = 1'b0;
    if (inTx && events.frameSent)
      next_flagsB[event_flag_pkg::B_SENT] = 1'b1;
    if (emptyNow)
    begin
      next_flagsB[event_flag_pkg::B_BODY] = 1'b0;
      next_flagsB[event_flag_pkg::B_CRC] = 1'b0;
    end
    if (inRx && events.lastByte && (events.crcPass || !control[event_flag_pkg::C_CRCON] ||
        control[event_flag_pkg::C_KEEP]))
      next_flagsB[event_flag_pkg::B_BODY] = 1'b1;
    if (inRx && events.crcPass)
      next_flagsB[event_flag_pkg::B_CRC] = 1'b1;
    if (wrB && wrData[event_flag_pkg::B_BATT])
      next_flagsB[event_flag_pkg::B_BATT] = 1'b0;
    if (events.batteryLow)
      next_flagsB[event_flag_pkg::B_BATT] = 1'b1;
  end
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      flagsA <= event_flag_pkg::FLAGS_PRIMARY_RESET;
      flagsB <= event_flag_pkg::FLAGS_QUEUE_RESET;
      control <= event_flag_pkg::CTRL_RESET;
      count <= 7'h00;
      queueFlush <= 1'b0;
      prevMode <= event_flag_pkg::MODE_SLEEP;
    end
    else
    begin
      flagsA <= next_flagsA;
      flagsB <= next_flagsB;
      control <= next_control;
      count <= next_count;
      queueFlush <= next_flush;
      prevMode <= radioMode;
    end
  end
  // ----------------------------------------
  // checks
  // ----------------------------------------
  AST_MODE_CLEAR: assert property (@(posedge clk) disable iff (!rst_n)
    modeChg |=> !flagsA[event_flag_pkg::B_MODE])
    else $error("mode flag not cleared on mode change");
  AST_RX_ONLY: assert property (@(posedge clk) disable iff (!rst_n)
    flagsA[event_flag_pkg::B_RXRDY] |-> $past(inRx))
    else $error("receive flag outside receive");
  AST_TX_ONLY: assert property (@(posedge clk) disable iff (!rst_n)
    flagsA[event_flag_pkg::B_TXRDY] |-> $past(inTx))
    else $error("transmit flag outside transmit");
  AST_LOCK_LIVE: assert property (@(posedge clk) disable iff (!rst_n)
    (events.synthLocked && inRx) |=> flagsA[event_flag_pkg::B_LOCK])
    else $error("lock flag not following");
  AST_STRENGTH_SET: assert property (@(posedge clk) disable iff (!rst_n)
    (inRx && signal_strength_value > signal_strength_limit) |=> flagsA[event_flag_pkg::B_STRENGTH])
    else $error("strength flag not set");
  AST_PREAMBLE_HOLD: assert property (@(posedge clk) disable iff (!rst_n)
    (flagsA[event_flag_pkg::B_PREAMBLE] && !wrA) |=> flagsA[event_flag_pkg::B_PREAMBLE])
    else $error("preamble flag lost");
  AST_FULL: assert property (@(posedge clk) disable iff (!rst_n)
    flagsB[event_flag_pkg::B_FULL] == (count == event_flag_pkg::QUEUE_DEPTH))
    else $error("full flag wrong");
  AST_EMPTY: assert property (@(posedge clk) disable iff (!rst_n)
    flagsB[event_flag_pkg::B_EMPTY] == (count == 7'h00))
    else $error("empty flag wrong");
  AST_LEVEL: assert property (@(posedge clk) disable iff (!rst_n)
    flagsB[event_flag_pkg::B_LEVEL] == (count > {1'b0, $past(queue_fill_limit)}))
    else $error("level flag wrong");
  AST_FLUSH: assert property (@(posedge clk) disable iff (!rst_n)
    queueFlush |-> count == 7'h00)
    else $error("flush left bytes");
  AST_BATT_STICKY: assert property (@(posedge clk) disable iff (!rst_n)
    (flagsB[event_flag_pkg::B_BATT] && !(wrB && wrData[event_flag_pkg::B_BATT]))
      |=> flagsB[event_flag_pkg::B_BATT])
    else $error("battery flag lost");
  // ----------------------------------------
  // checks on set and clear paths
  // ----------------------------------------
  AST_MODE_SET: assert property (@(posedge clk) disable iff (!rst_n)
    (events.mode_settled_flag && !modeChg) |=> flagsA[event_flag_pkg::B_MODE])
    else $error("mode flag not set when ready");
  AST_RX_SET: assert property (@(posedge clk) disable iff (!rst_n)
    (inRx && !modeChg && events.rxSettled) |=> flagsA[event_flag_pkg::B_RXRDY])
    else $error("receive flag not set");
  AST_RX_LEAVE: assert property (@(posedge clk) disable iff (!rst_n)
    leaveRx |=> !flagsA[event_flag_pkg::B_RXRDY])
    else $error("receive flag not cleared on leaving");
  AST_TX_SET: assert property (@(posedge clk) disable iff (!rst_n)
    (inTx && !modeChg && events.txRampDone) |=> flagsA[event_flag_pkg::B_TXRDY])
    else $error("transmit flag not set");
  AST_TX_LEAVE: assert property (@(posedge clk) disable iff (!rst_n)
    leaveTx |=> !flagsA[event_flag_pkg::B_TXRDY])
    else $error("transmit flag not cleared on leaving");
  AST_LOCK_IDLE: assert property (@(posedge clk) disable iff (!rst_n)
    (!events.synthLocked || radioMode == event_flag_pkg::MODE_SLEEP ||
      radioMode == event_flag_pkg::MODE_STANDBY) |=> !flagsA[event_flag_pkg::B_LOCK])
    else $error("lock flag high without lock");
  AST_STRENGTH_LEAVE: assert property (@(posedge clk) disable iff (!rst_n)
    leaveRx |=> !flagsA[event_flag_pkg::B_STRENGTH])
    else $error("strength flag not cleared on leaving");
  AST_STRENGTH_W1C: assert property (@(posedge clk) disable iff (!rst_n)
    (wrA && wrData[event_flag_pkg::B_STRENGTH] &&
      !(inRx && signal_strength_value > signal_strength_limit))
      |=> !flagsA[event_flag_pkg::B_STRENGTH])
    else $error("strength flag not cleared by write");
  AST_TIMEOUT_SET: assert property (@(posedge clk) disable iff (!rst_n)
    events.timeout |=> flagsA[event_flag_pkg::B_TIMEOUT])
    else $error("timeout flag not set");
  AST_TIMEOUT_CLEAR: assert property (@(posedge clk) disable iff (!rst_n)
    ((leaveRx || emptied) && !events.timeout) |=> !flagsA[event_flag_pkg::B_TIMEOUT])
    else $error("timeout flag not cleared");
  AST_TIMEOUT_HOLD: assert property (@(posedge clk) disable iff (!rst_n)
    (flagsA[event_flag_pkg::B_TIMEOUT] && !leaveRx && !emptied)
      |=> flagsA[event_flag_pkg::B_TIMEOUT])
    else $error("timeout flag lost");
  AST_PREAMBLE_SET: assert property (@(posedge clk) disable iff (!rst_n)
    events.preamble |=> flagsA[event_flag_pkg::B_PREAMBLE])
    else $error("preamble flag not set");
  AST_SYNC_SET: assert property (@(posedge clk) disable iff (!rst_n)
    events.syncHit |=> flagsA[event_flag_pkg::B_SYNC])
    else $error("sync flag not set");
  AST_SYNC_READONLY: assert property (@(posedge clk) disable iff (!rst_n)
    (flagsA[event_flag_pkg::B_SYNC] && !control[event_flag_pkg::C_CONT] && !leaveRx &&
      !emptied) |=> flagsA[event_flag_pkg::B_SYNC])
    else $error("sync flag cleared in packet mode");
  AST_QUEUE_SAT: assert property (@(posedge clk) disable iff (!rst_n)
    count <= event_flag_pkg::QUEUE_DEPTH)
    else $error("queue count beyond depth");
  AST_OVERRUN_SET: assert property (@(posedge clk) disable iff (!rst_n)
    (events.overrun && radioMode != event_flag_pkg::MODE_SLEEP)
      |=> flagsB[event_flag_pkg::B_OVERRUN])
    else $error("overrun flag not set");
  AST_OVERRUN_SLEEP: assert property (@(posedge clk) disable iff (!rst_n)
    (!flagsB[event_flag_pkg::B_OVERRUN] && radioMode == event_flag_pkg::MODE_SLEEP)
      |=> !flagsB[event_flag_pkg::B_OVERRUN])
    else $error("overrun flag set in sleep");
  AST_FLUSH_ONLY: assert property (@(posedge clk) disable iff (!rst_n)
    queueFlush |-> $past(wrB))
    else $error("flush without overrun clear");
  AST_SENT_SET: assert property (@(posedge clk) disable iff (!rst_n)
    (inTx && events.frameSent) |=> flagsB[event_flag_pkg::B_SENT])
    else $error("sent flag not set");
  AST_SENT_CLEAR: assert property (@(posedge clk) disable iff (!rst_n)
    leaveTx |=> !flagsB[event_flag_pkg::B_SENT])
    else $error("sent flag not cleared on leaving");
  AST_BODY_SET: assert property (@(posedge clk) disable iff (!rst_n)
    (inRx && events.lastByte && events.crcPass) |=> flagsB[event_flag_pkg::B_BODY])
    else $error("body flag not set");
  AST_BODY_CHECKED: assert property (@(posedge clk) disable iff (!rst_n)
    (inRx && events.lastByte && !events.crcPass && control[event_flag_pkg::C_CRCON] &&
      !control[event_flag_pkg::C_KEEP] && !flagsB[event_flag_pkg::B_BODY])
      |=> !flagsB[event_flag_pkg::B_BODY])
    else $error("body flag set on failed check");
  AST_BODY_CLEAR: assert property (@(posedge clk) disable iff (!rst_n)
    (emptyNow && !(inRx && events.lastByte)) |=> !flagsB[event_flag_pkg::B_BODY])
    else $error("body flag not cleared when empty");
  AST_CRC_SET: assert property (@(posedge clk) disable iff (!rst_n)
    (inRx && events.crcPass) |=> flagsB[event_flag_pkg::B_CRC])
    else $error("check flag not set");
  AST_CRC_CLEAR: assert property (@(posedge clk) disable iff (!rst_n)
    (emptyNow && !(inRx && events.crcPass)) |=> !flagsB[event_flag_pkg::B_CRC])
    else $error("check flag not cleared when empty");
  AST_BATT_SET: assert property (@(posedge clk) disable iff (!rst_n)
    events.batteryLow |=> flagsB[event_flag_pkg::B_BATT])
    else $error("battery flag not set");
  AST_CONTROL_QUIET: assert property (@(posedge clk) disable iff (!rst_n)
    !(wrPulse && address == event_flag_pkg::IDX_CONTROL) |=> $stable(control))
    else $error("control changed without write");
endmodule // radio_event_flag_registers

/* File: test/host_master.sv */
`timescale 1ns/1ps
module host_master (
  input wire logic clk,
  input wire logic waitrequest,
  input wire logic [31:0] readdata,
  output logic read,
  output logic write,
  output logic [7:0] address,
  output logic [31:0] writedata
);
  // ----------------------------------------
  // one bus cycle, held until accepted
  // ----------------------------------------
  initial
  begin
    read = 1'h0;
    write = 1'h0;
    address = 8'h0;
    writedata = 32'h0;
  end
  task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d,
    output logic [7:0] q);
    @(posedge clk);
    read <= ~w;
    write <= w;
    address <= a;
    writedata <= {24'h0, d};
    @(posedge clk);
    while (waitrequest !== 1'h0)
      @(posedge clk);
    q = readdata[7:0];
    read <= 1'h0;
    write <= 1'h0;
  endtask
endmodule // host_master

/* File: test/tb_top.sv */
`timescale 1ns/1ps
module tb_top;
  localparam logic [7:0] P = event_flag_pkg::IDX_FLAGS_PRIMARY;
  localparam logic [7:0] Q = event_flag_pkg::IDX_FLAGS_QUEUE;
  logic clk = 1'h0;
  logic rst_n = 1'h0;
  logic read, write, waitrequest, queuePush = 1'h0, queuePop = 1'h0, queueFlush;
  logic [7:0] address, sv = 8'h0;
  logic [7:0] sl = 8'h40;
  logic [5:0] fl = 6'h02;
  logic [31:0] writedata, readdata;
  logic [11:0] lvl = 12'h0;
  event_flag_pkg::radio_mode_t radioMode = event_flag_pkg::MODE_SLEEP;
  event_flag_pkg::radio_events_t events = '0;
  int checks = 0, n_mismatch = 0, cyc = 0, nFlush = 0;
  always #2.5 clk = ~clk;
  radio_event_flag_registers i_dut (.clk(clk), .rst_n(rst_n), .read(read), .write(write),
    .address(address), .writedata(writedata), .waitrequest(waitrequest),
    .readdata(readdata), .radioMode(radioMode), .events(events),
    .signal_strength_value(sv), .signal_strength_limit(sl),
    .queue_fill_limit(fl), .queuePush(queuePush), .queuePop(queuePop),
    .queueFlush(queueFlush));
  host_master i_host (.clk(clk), .waitrequest(waitrequest), .readdata(readdata),
    .read(read), .write(write), .address(address), .writedata(writedata));
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  always @(posedge clk)
  begin
    cyc++;
    if (queueFlush === 1'h1)
      nFlush++;
    if (cyc == 5000)
    begin
      n_mismatch++;
      close_out();
    end
  end
  task automatic close_out();
    $display("checks %0d n_mismatch %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("[FAIL] %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] q;
    i_host.xfer(1'h0, a, 8'h0, q);
    chk(q, e);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] q;
    i_host.xfer(1'h1, a, d, q);
  endtask
  // event bits: mode rx tx lock tmo pre sync ovr sent last crc batt
  task automatic pulse(input logic [11:0] v);
    @(posedge clk);
    events <= event_flag_pkg::radio_events_t'(v | lvl);
    @(posedge clk);
    events <= event_flag_pkg::radio_events_t'(lvl);
  endtask
  task automatic mode(input event_flag_pkg::radio_mode_t m);
    @(posedge clk);
    radioMode <= m;
    @(posedge clk);
  endtask
  task automatic fifo(input logic push, input int n);
    repeat (n)
    begin
      @(posedge clk);
      queuePush <= push;
      queuePop <= ~push;
    end
    @(posedge clk);
    queuePush <= 1'h0;
    queuePop <= 1'h0;
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_reset();
    rd(P, 8'h00);
    rd(Q, 8'h40);
    rd(8'h10, 8'h00);
  endtask
  task automatic t_modes();
    mode(event_flag_pkg::MODE_SYNTH);
    lvl = 12'h100;
    pulse(12'h800);
    rd(P, 8'h90);
    lvl = 12'h0;
    pulse(12'h0);
    rd(P, 8'h80);
    mode(event_flag_pkg::MODE_RX);
    rd(P, 8'h00);
    pulse(12'hc00);
    rd(P, 8'hc0);
    mode(event_flag_pkg::MODE_TX);
    rd(P, 8'h00);
    pulse(12'h208);
    rd(P, 8'h20);
    rd(Q, 8'h48);
    mode(event_flag_pkg::MODE_STANDBY);
    rd(P, 8'h00);
    rd(Q, 8'h40);
  endtask
  task automatic t_rx();
    mode(event_flag_pkg::MODE_RX);
    sv <= 8'h50;
    rd(P, 8'h08);
    sv <= 8'h10;
    wr(P, 8'h00);
    rd(P, 8'h08);
    wr(P, 8'h08);
    rd(P, 8'h00);
    sl <= 8'h60;
    sv <= 8'h50;
    rd(P, 8'h00);
    pulse(12'h0e0);
    wr(P, 8'h03);
    rd(P, 8'h05);
    fifo(1'h1, 1);
    fifo(1'h0, 1);
    rd(P, 8'h00);
    wr(event_flag_pkg::IDX_CONTROL, 8'h01);
    pulse(12'h020);
    wr(P, 8'h01);
    rd(P, 8'h00);
    wr(event_flag_pkg::IDX_CONTROL, 8'h00);
    pulse(12'h0a0);
    rd(P, 8'h05);
    mode(event_flag_pkg::MODE_STANDBY);
    rd(P, 8'h00);
  endtask
  task automatic t_queue();
    mode(event_flag_pkg::MODE_RX);
    fifo(1'h1, 2);
    rd(Q, 8'h00);
    fifo(1'h1, 1);
    rd(Q, 8'h20);
    fifo(1'h1, 63);
    pulse(12'h006);
    rd(Q, 8'ha6);
    fifo(1'h0, 1);
    rd(Q, 8'h26);
    fifo(1'h0, 65);
    rd(Q, 8'h40);
    wr(event_flag_pkg::IDX_CONTROL, 8'h02);
    fifo(1'h1, 1);
    pulse(12'h004);
    rd(Q, 8'h00);
    wr(event_flag_pkg::IDX_CONTROL, 8'h06);
    pulse(12'h004);
    rd(Q, 8'h04);
    wr(event_flag_pkg::IDX_CONTROL, 8'h00);
    fifo(1'h0, 1);
    rd(Q, 8'h40);
    fifo(1'h1, 3);
    pulse(12'h010);
    rd(Q, 8'h30);
    fl <= 6'h03;
    rd(Q, 8'h10);
    wr(Q, 8'h10);
    rd(Q, 8'h40);
    chk(8'(nFlush), 8'h01);
    mode(event_flag_pkg::MODE_SLEEP);
    pulse(12'h010);
    rd(Q, 8'h40);
  endtask
  task automatic t_batt();
    pulse(12'h001);
    mode(event_flag_pkg::MODE_RX);
    fifo(1'h1, 1);
    fifo(1'h0, 1);
    wr(Q, 8'h00);
    rd(Q, 8'h41);
    wr(Q, 8'h01);
    rd(Q, 8'h40);
  endtask
  initial
  begin
    repeat (16) @(posedge clk);
    rst_n <= 1'h1;
    t_reset();
    t_modes();
    t_rx();
    t_queue();
    t_batt();
    close_out();
  end
endmodule // tb_top
